// ---- rtl/sar_seq_pkg.sv ----
package sar_seq_pkg;
    // register byte addresses
    localparam logic [7:0] REF_SEL_ADDR     = 8'hea;
    localparam logic [7:0] INPUT_SEL_ADDR   = 8'heb;
    localparam logic [7:0] RES_MODE_ADDR    = 8'hec;
    localparam logic [7:0] SETTLE_ADDR      = 8'hee;
    localparam logic [7:0] CAP_LOW_ADDR     = 8'hef;
    localparam logic [7:0] CAP_AUX_ADDR     = 8'hf0;
    localparam logic [7:0] LENGTHS_ADDR     = 8'hf1;
    localparam logic [7:0] SEQ_CTRL_ADDR    = 8'hf2;
    localparam logic [7:0] HOLD_ADDR        = 8'hf3;
    localparam logic [7:0] CLK_DIV_ADDR     = 8'hf4;
    localparam logic [7:0] STATUS_ADDR      = 8'hf6;
    localparam logic [7:0] RESULT_LOW_ADDR  = 8'hf7;
    localparam logic [7:0] RESULT_HIGH_ADDR = 8'hf8;
    localparam logic [7:0] PRESCALE_ADDR    = 8'hfa;
    localparam logic [7:0] POWER_ADDR       = 8'hfc;
    // field positions
    localparam int DIFF_BIT    = 6;
    localparam int ENABLE_BIT  = 2;
    localparam int BLOCK_BIT   = 3;
    localparam int MAXIDX_LSB  = 4;
    localparam int CAPHI_LSB   = 6;
    localparam int SCALE_LSB   = 6;
    localparam int PD_BIT      = 5;
    // reset values
    localparam logic [1:0] REF_RST      = 2'h0;
    localparam logic [7:0] INPUT_RST    = 8'h00;
    localparam logic [1:0] RES_RST      = 2'h3;
    localparam logic       DIFF_RST     = 1'h0;
    localparam logic [3:0] SETTLE_RST   = 4'h0;
    localparam logic [7:0] BYTE_RST     = 8'h00;
    localparam logic [1:0] MAXIDX_RST   = 2'h0;
    localparam logic [2:0] DIV_RST      = 3'h3;
    localparam logic [1:0] SCALE_RST    = 2'h0;
    localparam logic       PD_RST       = 1'h1;
    // sequencer needs state index 2 (set + capture) to run
    localparam logic [1:0] MAXIDX_RUN   = 2'h2;
    // settling phase cycles per code step
    localparam int SETTLE_STEP = 3;
    typedef enum {SEQ_IDLE, SEQ_SET, SEQ_CAPTURE} seq_state_t;
endpackage

// ---- rtl/sar_adc_sequencer_regs.sv ----
// Functional notes
// - state lengths counted in reference clock cycles
// - capture length from ten-bit split field
// - set length from low nibble field
// - sampling runs only while channel enabled
// - block bit gates result delivery to core
// - two-bit max state index, resets zero
// - hold bit freezes the result bytes
// - converter clock is reference over divider+1
// - valid set at capture end, cleared in set
// - result read-only, low and high bytes
// - settling cycles from four-bit code
// - resolution 8/10/12/14 bits, resets to 14
// - differential mode bit, resets zero
// - positive input selector decode
// - negative input selector decode
// - reference select 0.9 V or 1.2 V
// - input prescale one or one eighth
// - reset powered down, clear before converting
// - run pulse at capture start, latch at end
// - result sign-extended to sixteen bits
// - one set then one capture state
`timescale 1ns/1ps
module sar_adc_sequencer_regs
    import sar_seq_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        rstn,
    input  wire logic [7:0]  regAddr,
    input  wire logic [7:0]  regWdata,
    input  wire logic        regWrite,
    input  wire logic        regRead,
    output logic      [7:0]  regRdata,
    input  wire logic [15:0] convData,
    output logic             convRun,
    output logic             convClock,
    output logic             convPowerDown,
    output logic      [3:0]  posInputSel,
    output logic      [3:0]  negInputSel,
    output logic             diffMode,
    output logic      [1:0]  referenceSel,
    output logic      [1:0]  resolution,
    output logic      [1:0]  inputPrescaleSelect,
    output logic      [5:0]  settleCycles,
    output logic             resultValid,
    output logic             coreStrobe,
    output logic      [15:0] coreData
);

    // configuration storage
    logic [7:0] captureLow;     // capture length bits 7:0
    logic [7:0] captureAux;     // plain storage byte
    logic [7:0] stateLengths;   // set nibble and capture bits 9:8
    logic [3:0] settleCode;     // settling phase code
    logic       chanEnable;     // sampling enable
    logic       coreBlock;      // one blocks delivery to core
    logic [1:0] maxIndex;       // highest state index
    logic       resultHold;     // one freezes result bytes
    logic [2:0] clkDiv;         // converter clock divider
    logic [15:0] result;        // result bytes

    // sequencer
    seq_state_t  seqState;
    seq_state_t  next_seqState;
    logic [9:0]  stateCnt;      // cycles spent in current state
    logic [2:0]  divCnt;        // converter clock phase
    logic [2:0]  next_divCnt;

    // write decode
    wire wrRef    = regWrite && regAddr == REF_SEL_ADDR;
    wire wrInput  = regWrite && regAddr == INPUT_SEL_ADDR;
    wire wrRes    = regWrite && regAddr == RES_MODE_ADDR;
    wire wrSettle = regWrite && regAddr == SETTLE_ADDR;
    wire wrCapLo  = regWrite && regAddr == CAP_LOW_ADDR;
    wire wrCapAux = regWrite && regAddr == CAP_AUX_ADDR;
    wire wrLen    = regWrite && regAddr == LENGTHS_ADDR;
    wire wrCtrl   = regWrite && regAddr == SEQ_CTRL_ADDR;
    wire wrHold   = regWrite && regAddr == HOLD_ADDR;
    wire wrDiv    = regWrite && regAddr == CLK_DIV_ADDR;
    wire wrScale  = regWrite && regAddr == PRESCALE_ADDR;
    wire wrPower  = regWrite && regAddr == POWER_ADDR;

    // state lengths; a zero length still takes one cycle
    wire [9:0] captureStateLength =
        {stateLengths[CAPHI_LSB+1:CAPHI_LSB], captureLow};
    wire [3:0] setLength = stateLengths[3:0];
    wire [9:0] setEnd = (setLength == 4'h0) ? 10'h000
                      : {6'h00, setLength - 4'h1};
    wire [9:0] capEnd = (captureStateLength == 10'h000) ? 10'h000
                      : captureStateLength - 10'h001;

    // run condition: enabled, powered, index reaches capture
    wire seqGo = chanEnable && !convPowerDown
              && maxIndex >= MAXIDX_RUN;
    wire setDone    = seqState == SEQ_SET && stateCnt == setEnd;
    wire captureEnd = seqState == SEQ_CAPTURE && stateCnt == capEnd;
    wire enterCap   = seqGo && setDone;

    // sign extension of the converter word by resolution
    function automatic logic [15:0] signExtend(
        input logic [15:0] d,
        input logic [1:0]  res
    );
        int top;
        logic [15:0] o;
        top = 7 + 2 * int'(res);
        o = d;
        for (int i = 0; i < 16; i++) begin
            if (i > top) begin
                o[i] = d[top];
            end
        end
        return o;
    endfunction
    wire [15:0] extData = signExtend(convData, resolution);

    // next state of the sequencer
    always_comb begin
        next_seqState = seqState;
        unique case (seqState)
            SEQ_IDLE: begin
                if (seqGo) begin
                    next_seqState = SEQ_SET;
                end
            end
            SEQ_SET: begin
                if (!seqGo) begin
                    next_seqState = SEQ_IDLE;
                end else if (setDone) begin
                    next_seqState = SEQ_CAPTURE;
                end
            end
            SEQ_CAPTURE: begin
                if (!seqGo) begin
                    next_seqState = SEQ_IDLE;
                end else if (captureEnd) begin
                    next_seqState = SEQ_SET;
                end
            end
        endcase
    end

    // converter clock phase wraps at the divider value
    assign next_divCnt = (divCnt >= clkDiv) ? 3'h0 : divCnt + 3'h1;

    // read selection; reserved bits and holes read zero, except lengths bits 5:4, which read back as written
    wire [7:0] readMux =
        (regAddr == REF_SEL_ADDR)   ? {6'h00, referenceSel} :
        (regAddr == INPUT_SEL_ADDR) ? {posInputSel, negInputSel} :
        (regAddr == RES_MODE_ADDR)  ? {1'b0, diffMode, 4'h0, resolution} :
        (regAddr == SETTLE_ADDR)    ? {4'h0, settleCode} :
        (regAddr == CAP_LOW_ADDR)   ? captureLow :
        (regAddr == CAP_AUX_ADDR)   ? captureAux :
        (regAddr == LENGTHS_ADDR)   ? stateLengths :
        (regAddr == SEQ_CTRL_ADDR)  ? {2'h0, maxIndex, coreBlock,
                                       chanEnable, 2'h0} :
        (regAddr == HOLD_ADDR)      ? {7'h00, resultHold} :
        (regAddr == CLK_DIV_ADDR)   ? {5'h00, clkDiv} :
        (regAddr == STATUS_ADDR)    ? {7'h00, resultValid} :
        (regAddr == RESULT_LOW_ADDR)  ? result[7:0] :
        (regAddr == RESULT_HIGH_ADDR) ? result[15:8] :
        (regAddr == PRESCALE_ADDR)  ? {inputPrescaleSelect, 6'h00} :
        (regAddr == POWER_ADDR)     ? {2'h0, convPowerDown, 5'h00} :
                                      8'h00;

    // software registers; result bytes have no write path
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            referenceSel        <= REF_RST;
            {posInputSel, negInputSel} <= INPUT_RST;
            resolution          <= RES_RST;
            diffMode            <= DIFF_RST;
            settleCode          <= SETTLE_RST;
            captureLow          <= BYTE_RST;
            captureAux          <= BYTE_RST;
            stateLengths        <= BYTE_RST;
            chanEnable          <= 1'b0;
            coreBlock           <= 1'b0;
            maxIndex            <= MAXIDX_RST;
            resultHold          <= 1'b0;
            clkDiv              <= DIV_RST;
            inputPrescaleSelect <= SCALE_RST;
            convPowerDown       <= PD_RST;
        end else begin
            if (wrRef) begin
                referenceSel <= regWdata[1:0];
            end
            if (wrInput) begin
                posInputSel <= regWdata[7:4];
                negInputSel <= regWdata[3:0];
            end
            if (wrRes) begin
                resolution <= regWdata[1:0];
                diffMode   <= regWdata[DIFF_BIT];
            end
            if (wrSettle) begin
                settleCode <= regWdata[3:0];
            end
            if (wrCapLo) begin
                captureLow <= regWdata;
            end
            if (wrCapAux) begin
                captureAux <= regWdata;
            end
            if (wrLen) begin
                stateLengths <= regWdata;
            end
            if (wrCtrl) begin
                chanEnable <= regWdata[ENABLE_BIT];
                coreBlock  <= regWdata[BLOCK_BIT];
                maxIndex   <= regWdata[MAXIDX_LSB+1:MAXIDX_LSB];
            end
            if (wrHold) begin
                resultHold <= regWdata[0];
            end
            if (wrDiv) begin
                clkDiv <= regWdata[2:0];
            end
            if (wrScale) begin
                inputPrescaleSelect <= regWdata[SCALE_LSB+1:SCALE_LSB];
            end
            if (wrPower) begin
                convPowerDown <= regWdata[PD_BIT];
            end
        end
    end

    // read data stands only in the cycle after the strobe
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            regRdata <= 8'h00;
        end else begin
            regRdata <= regRead ? readMux : 8'h00;
        end
    end

    // settling cycles: linear steps of three converter clocks
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            settleCycles <= 6'(SETTLE_STEP);
        end else begin
            settleCycles <= 6'(SETTLE_STEP * (int'(settleCode) + 1));
        end
    end

    // converter clock; held low while powered down to save power
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            divCnt    <= 3'h0;
            convClock <= 1'b0;
        end else begin
            divCnt    <= next_divCnt;
            convClock <= !convPowerDown
                      && next_divCnt <= (clkDiv >> 1);
        end
    end

    // state and length counter; counter restarts on each entry
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            seqState <= SEQ_IDLE;
            stateCnt <= 10'h000;
        end else begin
            seqState <= next_seqState;
            if (next_seqState != seqState) begin
                stateCnt <= 10'h000;
            end else begin
                stateCnt <= stateCnt + 10'h001;
            end
        end
    end

    // run pulse in the first capture cycle
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            convRun <= 1'b0;
        end else begin
            convRun <= enterCap;
        end
    end

    // result latch, valid flag and delivery to the core
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            result      <= 16'h0000;
            resultValid <= 1'b0;
            coreStrobe  <= 1'b0;
            coreData    <= 16'h0000;
        end else begin
            // set wins: capture end takes priority over clearing
            if (captureEnd && seqGo) begin
                resultValid <= 1'b1;
            end else if (seqState == SEQ_SET) begin
                resultValid <= 1'b0;
            end
            if (captureEnd && seqGo && !resultHold) begin
                result <= extData;
            end
            coreStrobe <= captureEnd && seqGo && !coreBlock;
            if (captureEnd && seqGo && !coreBlock) begin
                coreData <= extData;
            end
        end
    end

    // checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);

    sequence s_capEnd;
        seqState == SEQ_CAPTURE && stateCnt == capEnd && seqGo;
    endsequence

    property p_run_entry;
        convRun |-> seqState == SEQ_CAPTURE && stateCnt == 10'h000
                 && $past(seqState) == SEQ_SET;
    endproperty
    a_run_entry: assert property (p_run_entry)
        else $error("run pulse not at capture start");

    property p_set_len;
        seqState == SEQ_SET && stateCnt == setEnd && seqGo
            |=> seqState == SEQ_CAPTURE ##0 convRun;
    endproperty
    a_set_len: assert property (p_set_len)
        else $error("set state length wrong");

    property p_cap_len;
        seqState == SEQ_CAPTURE && stateCnt < capEnd && seqGo
            |=> seqState == SEQ_CAPTURE;
    endproperty
    a_cap_len: assert property (p_cap_len)
        else $error("capture ended early");

    property p_valid;
        s_capEnd |=> resultValid && seqState == SEQ_SET
                 ##1 !resultValid;
    endproperty
    a_valid: assert property (p_valid)
        else $error("valid flag timing wrong");

    property p_hold;
        resultHold |=> $stable(result);
    endproperty
    a_hold: assert property (p_hold)
        else $error("result changed while held");

    property p_latch;
        s_capEnd ##0 !resultHold |=> result == $past(extData);
    endproperty
    a_latch: assert property (p_latch)
        else $error("result not latched at capture end");

    property p_block;
        coreStrobe |-> !$past(coreBlock) && $past(captureEnd);
    endproperty
    a_block: assert property (p_block)
        else $error("delivery while blocked");

    property p_disabled;
        !chanEnable || convPowerDown |=> seqState == SEQ_IDLE
                                      && !resultValid[*1];
    endproperty
    a_disabled: assert property (p_disabled)
        else $error("sequencer ran while disabled");

    property p_power_run;
        convPowerDown |=> !convRun && !convClock;
    endproperty
    a_power_run: assert property (p_power_run)
        else $error("activity while powered down");

    property p_read_result;
        regRead && regAddr == RESULT_HIGH_ADDR
            |=> regRdata == $past(result[15:8]) ##1 regRdata == 8'h00
                || $past(regRead);
    endproperty
    a_read_result: assert property (p_read_result)
        else $error("result high read wrong");

endmodule

// ---- tb/sar_core_model.sv ----
`timescale 1ns/1ps
// behavioural stand-in for the analog converter core
module sar_core_model (
    input  wire logic        clk,
    input  wire logic        rstn,
    input  wire logic        convRun,
    input  wire logic        convPowerDown,
    output logic      [15:0] convData
);
    // a run launches a new code that stands until the next run or power-down
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            convData <= 16'h8421;
        end else if (convPowerDown) begin
            // a sleeping core gives no stable word, so keep it moving
            convData <= ~convData;
        end else if (convRun) begin
            // step chosen so the sign bits differ between codes
            convData <= convData + 16'h3b59;
        end
    end
endmodule

// ---- tb/sar_adc_sequencer_regs_tb.sv ----
`timescale 1ns/1ps
module sar_adc_sequencer_regs_tb;
    import sar_seq_pkg::*;
    logic        clk, rstn, regWrite, regRead;      // clock, reset, strobes
    logic [7:0]  regAddr, regWdata, regRdata;       // register bus
    logic [15:0] convData, coreData;                // converter and core words
    logic        convRun, convClock, convPowerDown; // converter controls
    logic        diffMode, resultValid, coreStrobe; // mode and status
    logic [3:0]  posInputSel, negInputSel;          // input selectors
    logic [1:0]  referenceSel, resolution, inputPrescaleSelect;
    logic [5:0]  settleCycles;                      // settling count
    int          error_cnt, num_checks, cycleCnt;   // bookkeeping
    logic [7:0]  rv, rv2;                           // read results
    logic [15:0] saved;                             // last delivered word
    int          nr, nv, ns, nc, g;                 // pulse counts

    sar_adc_sequencer_regs dut_u (.clk(clk), .rstn(rstn), .regAddr(regAddr),
        .regWdata(regWdata), .regWrite(regWrite), .regRead(regRead),
        .regRdata(regRdata), .convData(convData), .convRun(convRun),
        .convClock(convClock), .convPowerDown(convPowerDown),
        .posInputSel(posInputSel), .negInputSel(negInputSel),
        .diffMode(diffMode), .referenceSel(referenceSel),
        .resolution(resolution), .inputPrescaleSelect(inputPrescaleSelect),
        .settleCycles(settleCycles), .resultValid(resultValid),
        .coreStrobe(coreStrobe), .coreData(coreData));
    sar_core_model core_u (.clk(clk), .rstn(rstn), .convRun(convRun),
        .convPowerDown(convPowerDown), .convData(convData));

    // free-running 50 MHz clock
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    // hang guard: the whole sequence needs under two thousand cycles
    always @(posedge clk) begin
        cycleCnt++;
        if (cycleCnt == 30000) begin
            error_cnt++;
            report_and_stop();
        end
    end
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    task automatic chk(input string what, input logic [15:0] exp, got);
        num_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("FAIL %s expected %h seen %h", what, exp, got);
        end
    endtask
    // one-cycle write; a gap cycle keeps strobes single-assigned
    task automatic wr(input logic [7:0] a, d);
        @(posedge clk);
        regAddr <= a;
        regWdata <= d;
        regWrite <= 1'b1;
        @(posedge clk);
        regWrite <= 1'b0;
    endtask
    // data stand in the cycle after the strobe, taken at its closing edge
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk);
        regAddr <= a;
        regRead <= 1'b1;
        @(posedge clk);
        regRead <= 1'b0;
        @(posedge clk);
        d = regRdata;
    endtask
    // sign extension from the top bit of the chosen resolution
    function automatic logic [15:0] sext(input logic [15:0] d, input int r);
        logic [15:0] v;
        v = d;
        for (int i = 8 + 2 * r; i < 16; i++) v[i] = d[7 + 2 * r];
        return v;
    endfunction
    // count pulses and converter clock rises over a window
    task automatic count(input int n, output int cr, cv, cs, ck);
        logic prev;
        cr = 0; cv = 0; cs = 0; ck = 0;
        prev = convClock;
        repeat (n) begin
            @(negedge clk);
            cr += (convRun === 1'b1);
            cv += (resultValid === 1'b1);
            cs += (coreStrobe === 1'b1);
            ck += (convClock === 1'b1 && prev === 1'b0);
            prev = convClock;
        end
    endtask
    task automatic wait_core();
        int k;
        k = 0;
        @(negedge clk);
        while (coreStrobe !== 1'b1 && k < 1000) begin
            @(negedge clk);
            k++;
        end
        chk("coreStrobe", 1, coreStrobe);
    endtask
    // cycles from the run pulse to the valid flag, i.e. capture length
    task automatic gap(output int n);
        int k;
        k = 0;
        while (convRun !== 1'b1 && k < 1000) begin
            @(negedge clk);
            k++;
        end
        n = 0;
        while (resultValid !== 1'b1 && n < 1000) begin
            @(negedge clk);
            n++;
        end
    endtask

    task automatic t_reset();
        logic [7:0] a [11] = '{8'hea, 8'heb, 8'hec, 8'hee, 8'hf2, 8'hf3,
                               8'hf4, 8'hf6, 8'hfa, 8'hfc, 8'hf5};
        logic [7:0] e [11] = '{8'h00, 8'h00, 8'h03, 8'h00, 8'h00, 8'h00,
                               8'h03, 8'h00, 8'h00, 8'h20, 8'h00};
        for (int i = 0; i < 11; i++) begin
            rd(a[i], rv);
            chk("reset read", e[i], rv);
        end
        chk("powerDown", 1, convPowerDown);
        chk("settle", 3, settleCycles);
        chk("convClock", 0, convClock);
        $display("test reset done");
    endtask
    task automatic t_fields();
        for (int i = 0; i < 16; i++) begin
            wr(INPUT_SEL_ADDR, {i[3:0], 4'hf - i[3:0]});
            @(negedge clk);
            chk("posSel", i, posInputSel);
            chk("negSel", 15 - i, negInputSel);
            wr(SETTLE_ADDR, {4'h0, i[3:0]});
            // settling count follows the code one clock later
            repeat (2) @(negedge clk);
            chk("settle", 3 * (i + 1), settleCycles);
        end
        for (int r = 0; r < 4; r++) begin
            wr(REF_SEL_ADDR, {6'h00, r[1:0]});
            wr(PRESCALE_ADDR, {r[1:0], 6'h00});
            wr(RES_MODE_ADDR, {2'h1, 4'h0, r[1:0]});
            @(negedge clk);
            chk("refSel", r, referenceSel);
            chk("prescale", r, inputPrescaleSelect);
            chk("resolution", r, resolution);
            chk("diffMode", 1, diffMode);
        end
        wr(RES_MODE_ADDR, 8'hff);
        rd(RES_MODE_ADDR, rv);
        chk("mode readback", 8'h43, rv);
        $display("test fields done");
    endtask
    task automatic t_seq();
        wr(POWER_ADDR, 8'h00);
        wr(CLK_DIV_ADDR, 8'h05);
        count(12, nr, nv, ns, nc);
        count(60, nr, nv, ns, nc);
        chk("convClock rises", 10, nc);
        wr(LENGTHS_ADDR, 8'h02);
        wr(CAP_LOW_ADDR, 8'h03);
        wr(SEQ_CTRL_ADDR, 8'h24);
        gap(g);
        chk("capture len", 3, g);
        count(50, nr, nv, ns, nc);
        chk("runs", 10, nr);
        chk("valid cycles", 10, nv);
        chk("core strobes", 10, ns);
        wr(LENGTHS_ADDR, 8'h42);
        gap(g);
        chk("long capture", 259, g);
        count(522, nr, nv, ns, nc);
        chk("long runs", 2, nr);
        wr(LENGTHS_ADDR, 8'h02);
        $display("test sequence done");
    endtask
    task automatic t_result();
        for (int r = 0; r < 4; r++) begin
            wr(RES_MODE_ADDR, {2'h1, 4'h0, r[1:0]});
            wait_core();
            chk("coreData", sext(convData, r), coreData);
        end
        wait_core();
        saved = coreData;
        wr(SEQ_CTRL_ADDR, 8'h20);
        rd(RESULT_LOW_ADDR, rv);
        rd(RESULT_HIGH_ADDR, rv2);
        chk("result pair", saved, {rv2, rv});
        wr(RESULT_LOW_ADDR, 8'hff);
        rd(RESULT_LOW_ADDR, rv);
        chk("result low ro", saved[7:0], rv);
        wr(HOLD_ADDR, 8'h01);
        wr(SEQ_CTRL_ADDR, 8'h24);
        wait_core();
        chk("coreData held", sext(convData, 3), coreData);
        wr(SEQ_CTRL_ADDR, 8'h20);
        rd(RESULT_LOW_ADDR, rv);
        rd(RESULT_HIGH_ADDR, rv2);
        chk("frozen pair", saved, {rv2, rv});
        wr(SEQ_CTRL_ADDR, 8'h2c);
        count(50, nr, nv, ns, nc);
        chk("blocked runs", 10, nr);
        chk("blocked strobes", 0, ns);
        $display("test result done");
    endtask
    task automatic t_stop();
        logic [7:0] c [3] = '{8'h20, 8'h14, 8'h24};
        for (int i = 0; i < 3; i++) begin
            if (i == 2) wr(POWER_ADDR, 8'h20);
            wr(SEQ_CTRL_ADDR, c[i]);
            count(50, nr, nv, ns, nc);
            chk("stopped runs", 0, nr);
        end
        chk("sleeping clock", 0, nc);
        $display("test stop done");
    endtask

    initial begin
        rstn = 1'b0;
        regWrite = 1'b0;
        regRead = 1'b0;
        regAddr = 8'h00;
        regWdata = 8'h00;
        repeat (20) @(posedge clk);
        rstn <= 1'b1;
        t_reset();
        t_fields();
        t_seq();
        t_result();
        t_stop();
        report_and_stop();
    end
endmodule
